// >>> verilog/ersm_rx_sys_mux.sv
`timescale 1ns/10ps
`include "ersm_regs.svh"
// Summary of operation
// - Fractional master mode gaps a framer's clock in slots flagged idle.
// - Data under a gapped clock is meaningless; the system ignores it.
// - Bit 1 of every slot leaves first, rest follow in order.
// - F-bit variant gaps slot 16 and slot 26 bit 2 to frame end.
// - F-bit variant ignores idle flags of forced slots; others follow flags.
// - Multiplexed mode drives two buses, four framers interleaved per bus.
// - Each framer drives the bus its bus select bit picks.
// - Slot offset places framer bytes; software keeps offsets distinct.
// - Bus enable gates a framer onto its bus; sharers agree.
// - Frame edge bit samples pulse and pulse out; data edge updates data.
// - Differing edge bits put the pulse out one edge ahead of data.
// - Double rate with equal edges: update on first edge, ignore choice.
// - Double rate: choice bit picks data edge; pulse sampled on first.
// - Rate and edge-choice bits set in any framer count for all.
// - Frame pulse mode zero keeps the common frame pulse off the bit counter; repeat select still copies it to pulse out.
// - Two bits pick pulse out: zero, frame position, or repeat.
// - Frame position marks only basic frame start, with invert polarity.
// - Signaling output is slot aligned with the data output.
// - Out of signaling multiframe with force bit, ABCD are all ones.
// - Master mode clock runs at 2.048 MHz apart from gapping.
module ersm_rx_sys_mux
	import ersm_pkg::*;
#(
	parameter int FRAMERS = 8
) (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  common_bus_clock,
	input  wire logic                  common_frame_pulse,
	input  wire logic [FRAMERS*8-1:0]  framer_byte,
	input  wire logic [FRAMERS*4-1:0]  framer_sig,
	input  wire logic [FRAMERS-1:0]    sig_multiframe_lost,
	output logic      [FRAMERS*5-1:0]  framer_slot_idx,
	output logic      [FRAMERS-1:0]    framer_rx_out_clock,
	output logic      [FRAMERS-1:0]    framer_rx_data,
	output logic      [1:0]            muxed_data_out,
	output logic      [1:0]            muxed_signaling_out,
	output logic      [1:0]            muxed_frame_pulse_out
);

	// *************************************************************
	// Register file
	// *************************************************************

	logic [31:0] cfg  [FRAMERS];
	logic [31:0] idle [FRAMERS];
	logic [2:0]  ctrl;

	// Address decode shared by read and write paths
	function automatic ersm_reg_kind_t ersm_decode(input logic [7:0] a);
		ersm_reg_kind_t k;
		k = ERSM_REG_NONE;
		if (a[1:0] != 2'h0)
			k = ERSM_REG_NONE;
		else if (a >= `ERSM_CFG_BASE && a < `ERSM_CFG_BASE + 8'(FRAMERS * 4))
			k = ERSM_REG_CFG;
		else if (a >= `ERSM_IDLE_BASE && a < `ERSM_IDLE_BASE + 8'(FRAMERS * 4))
			k = ERSM_REG_IDLE;
		else if (a == `ERSM_CTRL_OFS)
			k = ERSM_REG_CTRL;
		else if (a == `ERSM_STATUS_OFS)
			k = ERSM_REG_STATUS;
		return k;
	endfunction : ersm_decode

	ersm_reg_kind_t kind;
	logic [2:0]     ridx;
	logic           access;
	logic           wr_take;
	logic [31:0]    rd_value;
	logic [9:0]     bus_cnt;
	logic [7:0]     m_cnt;
	logic           clk_lvl;
	logic           fp_lvl;

	assign kind    = ersm_decode(paddr);
	assign ridx    = paddr[4:2];
	assign access  = psel & penable;
	assign wr_take = access & pready & pwrite;

	// Read mux
	always_comb begin
		rd_value = 32'h0000_0000;
		case (kind)
			ERSM_REG_CFG:    rd_value = cfg[ridx];
			ERSM_REG_IDLE:   rd_value = idle[ridx];
			ERSM_REG_CTRL:   rd_value = {29'h0000_0000, ctrl};
			ERSM_REG_STATUS: rd_value = {12'h000, bus_cnt, m_cnt, clk_lvl, fp_lvl};
			default:         rd_value = 32'h0000_0000;
		endcase
	end

	// One wait state, answer in second access cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= access & ~pready;
			prdata  <= (access & ~pready & ~pwrite) ? rd_value : 32'h0000_0000;
			pslverr <= access & ~pready & (kind == ERSM_REG_NONE);
		end
	end

	// Register writes at the completing edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl <= `ERSM_CTRL_RST;
			for (int i = 0; i < FRAMERS; i++) begin
				cfg[i]  <= `ERSM_CFG_RST;
				idle[i] <= `ERSM_IDLE_RST;
			end
		end else if (wr_take) begin
			case (kind)
				ERSM_REG_CFG:  cfg[ridx]  <= pwdata;
				ERSM_REG_IDLE: idle[ridx] <= pwdata;
				ERSM_REG_CTRL: ctrl       <= pwdata[2:0];
				default:       ctrl       <= ctrl;
			endcase
		end
	end

	// *************************************************************
	// Global settings
	// *************************************************************

	logic mux_mode;
	logic frac_mode;
	logic fbit_mode;
	logic cms_any;
	logic oec_any;
	logic fe_sel;
	logic de_sel;
	logic fp_inv;
	logic fp_mode;
	ersm_pulse_sel_t pulse_sel;

	assign mux_mode  = ctrl[`ERSM_CTRL_MUX];
	assign frac_mode = ctrl[`ERSM_CTRL_FRAC];
	assign fbit_mode = ctrl[`ERSM_CTRL_FBIT];
	// Shared bus timing follows framer 0; the others are expected to match
	assign fe_sel    = cfg[0][`ERSM_CFG_FE];
	assign de_sel    = cfg[0][`ERSM_CFG_DE];
	assign fp_inv    = cfg[0][`ERSM_CFG_FRAME_PULSE_INVERT];
	assign fp_mode   = cfg[0][`ERSM_CFG_FRAME_PULSE_MODE];
	assign pulse_sel = ersm_pulse_sel_t'(cfg[0][`ERSM_CFG_PCFG_HI:`ERSM_CFG_PCFG_LO]);

	// Rate and edge choice are OR-ed across all framers
	always_comb begin
		cms_any = 1'b0;
		oec_any = 1'b0;
		for (int i = 0; i < FRAMERS; i++) begin
			cms_any = cms_any | cfg[i][`ERSM_CFG_CMS];
			oec_any = oec_any | cfg[i][`ERSM_CFG_OEC];
		end
	end

	// *************************************************************
	// Pin synchronisers
	// *************************************************************

	logic [2:0] ck_s;
	logic [2:0] fp_s;
	logic       ck_rise;
	logic       ck_fall;

	// Three stages; a change counts when stages two and three agree
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ck_s    <= 3'h0;
			fp_s    <= 3'h0;
			clk_lvl <= 1'b0;
			fp_lvl  <= 1'b0;
		end else begin
			ck_s <= {ck_s[1:0], common_bus_clock};
			fp_s <= {fp_s[1:0], common_frame_pulse};
			if (ck_s[1] == ck_s[2])
				clk_lvl <= ck_s[2];
			if (fp_s[1] == fp_s[2])
				fp_lvl <= fp_s[2];
		end
	end

	assign ck_rise = (ck_s[1] == ck_s[2]) & ck_s[2] & ~clk_lvl;
	assign ck_fall = (ck_s[1] == ck_s[2]) & ~ck_s[2] & clk_lvl;

	// *************************************************************
	// Multiplexed bus timing
	// *************************************************************

	logic       fe_edge;
	logic       de_edge;
	logic       ph;
	logic       bit_start;
	logic       pulse_hit;
	logic [9:0] nb;
	logic       data_upd;
	logic       same_edge;

	assign fe_edge   = fe_sel ? ck_fall : ck_rise;
	assign de_edge   = de_sel ? ck_fall : ck_rise;
	assign same_edge = (fe_sel == de_sel);
	// At double rate only the first frame edge opens a bit
	assign bit_start = mux_mode & fe_edge & (~cms_any | ~ph);
	assign pulse_hit = fp_mode & (fp_lvl ^ fp_inv);
	assign nb        = pulse_hit ? 10'h000 : bus_cnt + 10'h001;

	// Data update edge selection
	always_comb begin
		if (!mux_mode)
			data_upd = 1'b0;
		else if (same_edge)
			data_upd = bit_start;
		else if (cms_any)
			data_upd = de_edge & (~ph == oec_any);
		else
			data_upd = de_edge;
	end

	// Bit counter and double-rate phase
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_cnt <= 10'h3ff;
			ph      <= 1'b0;
		end else begin
			if (mux_mode && fe_edge)
				ph <= cms_any ? ~ph : 1'b0;
			if (bit_start)
				bus_cnt <= nb;
		end
	end

	// *************************************************************
	// Per-framer byte selection
	// *************************************************************

	logic [1:0] bus_d;
	logic [1:0] bus_s;
	logic [FRAMERS-1:0] drv;
	logic [FRAMERS-1:0] bit_d;
	logic [FRAMERS-1:0] bit_s;
	logic [FRAMERS*5-1:0] next_slot_idx;
	logic [2:0] kbit;
	logic [7:0] m_next;

	assign kbit   = nb[2:0];
	assign m_next = m_cnt + 8'h01; // Master bit about to be sent

	for (genvar g = 0; g < FRAMERS; g++) begin : g_framer
		logic [6:0] rel;
		logic [7:0] byt;
		logic [3:0] sig;
		assign rel = nb[9:3] - cfg[g][`ERSM_CFG_OFS_HI:`ERSM_CFG_OFS_LO];
		assign byt = framer_byte[g*8 +: 8];
		assign sig = framer_sig[g*4 +: 4];
		assign drv[g] = cfg[g][`ERSM_CFG_BUSEN] & (rel[1:0] == 2'h0);
		// Bit 1 is the byte's most significant bit
		assign bit_d[g] = byt[3'h7 - kbit];
		// ABCD in bits 5 to 8, filler zero in bits 1 to 4
		assign bit_s[g] = ~kbit[2] ? 1'b0 :
			(cfg[g][`ERSM_CFG_SIGONES] & sig_multiframe_lost[g]) ? 1'b1 :
			sig[2'h3 - kbit[1:0]];
		// Slot looked up ahead, for the bit about to be sent
		assign next_slot_idx[g*5 +: 5] = mux_mode ? rel[6:2] : m_next[7:3];
	end

	// Bus merge by select bit
	always_comb begin
		bus_d = 2'h0;
		bus_s = 2'h0;
		for (int i = 0; i < FRAMERS; i++) begin
			if (drv[i]) begin
				bus_d[cfg[i][`ERSM_CFG_BUSSEL]] = bus_d[cfg[i][`ERSM_CFG_BUSSEL]] | bit_d[i];
				bus_s[cfg[i][`ERSM_CFG_BUSSEL]] = bus_s[cfg[i][`ERSM_CFG_BUSSEL]] | bit_s[i];
			end
		end
	end

	// *************************************************************
	// Multiplexed outputs
	// *************************************************************

	logic [1:0] hold_d;
	logic [1:0] hold_s;
	logic       fp_next;

	// Frame pulse source
	always_comb begin
		case (pulse_sel)
			ERSM_PULSE_ZERO:   fp_next = 1'b0;
			ERSM_PULSE_REPEAT: fp_next = fp_lvl;
			ERSM_PULSE_MARK:   fp_next = (nb == 10'h000) ^ fp_inv;
			default:           fp_next = 1'b0;
		endcase
	end

	// Pulse at the frame edge, data held until its own edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hold_d                <= 2'h0;
			hold_s                <= 2'h0;
			muxed_data_out        <= 2'h0;
			muxed_signaling_out   <= 2'h0;
			muxed_frame_pulse_out <= 2'h0;
		end else begin
			if (bit_start) begin
				hold_d                <= bus_d;
				hold_s                <= bus_s;
				muxed_frame_pulse_out <= {fp_next, fp_next};
			end
			if (data_upd) begin
				muxed_data_out      <= (same_edge & bit_start) ? bus_d : hold_d;
				muxed_signaling_out <= (same_edge & bit_start) ? bus_s : hold_s;
			end
		end
	end

	// *************************************************************
	// Clock master outputs
	// *************************************************************

	logic [31:0] nco;
	logic        nco_msb_q;
	logic        m_fall;
	logic        forced_gap;

	assign m_fall = nco_msb_q & ~nco[31];

	// Slot 16 whole, slot 26 from bit 2 to frame end
	assign forced_gap = fbit_mode & ((m_cnt[7:3] == `ERSM_FBIT_SLOT_A) |
		(m_cnt[7:3] == `ERSM_FBIT_SLOT_B && m_cnt[2:0] != 3'h0) |
		(m_cnt[7:3] > `ERSM_FBIT_SLOT_B));

	// 2.048 MHz phase accumulator and bit counter
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			nco       <= 32'h0000_0000;
			nco_msb_q <= 1'b0;
			m_cnt     <= 8'hff;
		end else begin
			nco       <= nco + `ERSM_NCO_INC;
			nco_msb_q <= nco[31];
			if (m_fall)
				m_cnt <= m_cnt + 8'h01;
		end
	end

	// Data changes on the falling half, clock gated per slot
	for (genvar g = 0; g < FRAMERS; g++) begin : g_master
		logic       gap;
		logic [2:0] nbit;
		// Data under a gap is still shifted but carries no meaning
		assign gap  = frac_mode & (forced_gap | idle[g][m_cnt[7:3]]);
		assign nbit = 3'(m_cnt[2:0] + 3'h1);
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				framer_rx_out_clock[g] <= 1'b0;
				framer_rx_data[g]      <= 1'b0;
			end else begin
				framer_rx_out_clock[g] <= ~mux_mode & nco[31] & ~gap;
				if (m_fall)
					framer_rx_data[g] <= ~mux_mode & framer_byte[g*8 + 7 - nbit];
			end
		end
	end

	// Slot index toward the framer cores
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			framer_slot_idx <= '0;
		else
			framer_slot_idx <= next_slot_idx;
	end

endmodule : ersm_rx_sys_mux

// >>> verilog/ersm_regs.svh
`ifndef ERSM_REGS_SVH
`define ERSM_REGS_SVH

// Register byte offsets
`define ERSM_CFG_BASE       8'h00
`define ERSM_IDLE_BASE      8'h20
`define ERSM_CTRL_OFS       8'h40
`define ERSM_STATUS_OFS     8'h44

// Per-framer configuration fields
`define ERSM_CFG_SIGONES    2
`define ERSM_CFG_BUSEN      3
`define ERSM_CFG_BUSSEL     4
`define ERSM_CFG_CMS        8
`define ERSM_CFG_FE         9
`define ERSM_CFG_DE         10
`define ERSM_CFG_OEC        11
`define ERSM_CFG_FRAME_PULSE_INVERT      12
`define ERSM_CFG_FRAME_PULSE_MODE     13
`define ERSM_CFG_PCFG_LO    14
`define ERSM_CFG_PCFG_HI    15
`define ERSM_CFG_OFS_LO     16
`define ERSM_CFG_OFS_HI     22

// Global control fields
`define ERSM_CTRL_MUX       0
`define ERSM_CTRL_FRAC      1
`define ERSM_CTRL_FBIT      2

// Reset values
`define ERSM_CFG_RST        32'h0000_0000
`define ERSM_IDLE_RST       32'h0000_0000
`define ERSM_CTRL_RST       3'h0

// Timing
`define ERSM_CLK_HZ         64'd200000000
`define ERSM_MASTER_HZ      64'd2048000
`define ERSM_NCO_INC        32'((`ERSM_MASTER_HZ * 64'h1_0000_0000) / `ERSM_CLK_HZ)

// Forced gap positions of the F-bit variant
`define ERSM_FBIT_SLOT_A    5'h10
`define ERSM_FBIT_SLOT_B    5'h1a

`endif

// >>> verilog/ersm_pkg.sv
package ersm_pkg;

	// Frame pulse output source
	typedef enum logic [1:0] {
		ERSM_PULSE_ZERO   = 2'b00,
		ERSM_PULSE_REPEAT = 2'b01,
		ERSM_PULSE_MARK   = 2'b10,
		ERSM_PULSE_RSVD   = 2'b11
	} ersm_pulse_sel_t;

	// Register kind found by the decoder
	typedef enum logic [2:0] {
		ERSM_REG_NONE   = 3'b000,
		ERSM_REG_CFG    = 3'b001,
		ERSM_REG_IDLE   = 3'b010,
		ERSM_REG_CTRL   = 3'b011,
		ERSM_REG_STATUS = 3'b100
	} ersm_reg_kind_t;

endpackage : ersm_pkg

// >>> bench/ersm_asserts.sv
`timescale 1ns/10ps
// ****
// Port checker
// ****
module ersm_asserts #(
	parameter int FRAMERS = 8
) (
	input wire logic			clk,
	input wire logic			rst,
	input wire logic			psel,
	input wire logic			penable,
	input wire logic			pwrite,
	input wire logic [7:0]		paddr,
	input wire logic [31:0]		pwdata,
	input wire logic [31:0]		prdata,
	input wire logic			pready,
	input wire logic			pslverr,
	input wire logic			common_bus_clock,
	input wire logic [FRAMERS-1:0]	framer_rx_out_clock,
	input wire logic [1:0]		muxed_data_out,
	input wire logic [1:0]		muxed_frame_pulse_out
);
	logic	[15:0]	cfg0;
	logic	[2:0]	ctrl;
	logic	[3:0]	age;
	logic	[3:0]	since;
	logic			bclk_q;
	logic			steady;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Shadow of framer 0 config and mode, age since last write
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg0 <= 16'h0000;
			ctrl <= 3'h0;
			age <= 4'h0;
		end else if (psel && penable && pready && pwrite) begin
			if (paddr == 8'h00) cfg0 <= pwdata[15:0];
			if (paddr == 8'h40) ctrl <= pwdata[2:0];
			age <= 4'h0;
		end else if (age != 4'hf) age <= age + 4'h1;
	end
	// Cycles since the raw bus clock rose
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bclk_q <= 1'b0;
			since <= 4'hf;
		end else begin
			bclk_q <= common_bus_clock;
			if (common_bus_clock && !bclk_q) since <= 4'h0;
			else if (since != 4'hf) since <= since + 4'h1;
		end
	end
	assign steady = ctrl[0] && age == 4'hf && cfg0[10:9] == 2'b00;
	sequence s_access; psel && penable && !pready; endsequence
	sequence s_answer; pready ##1 !pready; endsequence
	a_ready_follows: assert property (s_access |=> s_answer)
		else $error("ready missing or too long");
	a_ready_cause: assert property (pready |-> $past(psel && penable))
		else $error("ready without access");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	a_err_map: assert property (pready |-> pslverr == (paddr[1:0] != 2'b00 || paddr > 8'h44))
		else $error("error flag wrong");
	a_pulse_zero: assert property (age == 4'hf && cfg0[15:14] == 2'b00 |->
		muxed_frame_pulse_out == 2'b00) else $error("pulse out not zero");
	a_master_quiet: assert property (ctrl[0] && age == 4'hf |->
		framer_rx_out_clock == '0) else $error("master clock in mux mode");
	a_data_edge: assert property (steady && $changed(muxed_data_out) |->
		since <= 4'h8) else $error("data off its edge");
	a_pulse_edge: assert property (steady && $changed(muxed_frame_pulse_out) |->
		since <= 4'h8) else $error("pulse off its edge");
endmodule : ersm_asserts

// >>> bench/ersm_backplane.sv
`timescale 1ns/10ps
// ****
// System backplane: bus clock and frame pulse
// ****
module ersm_backplane (
	input wire logic	invert,
	output logic		common_bus_clock,
	output logic		common_frame_pulse
);
	int bit_count = 0;
	initial common_bus_clock = 1'b0;
	initial common_frame_pulse = 1'b0;
	// Bus clock at the stream bit rate, 80 ns
	always #40 common_bus_clock = ~common_bus_clock;
	// Pulse on bit 1 of each 1024-bit frame, launched at the fall
	always @(negedge common_bus_clock) begin
		bit_count = (bit_count + 1) % 1024;
		common_frame_pulse = (bit_count == 0) ^ invert;
	end
endmodule : ersm_backplane

// >>> bench/testbench.sv
`timescale 1ns/10ps
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin fail_count++; \
	$display("wrong value at %0t: %s", $time, m); end end
// ****
// Bench top
// ****
module testbench;
	logic			clk = 1'b0;
	logic			rst = 1'b1;
	logic			psel = 1'b0;
	logic			penable = 1'b0;
	logic			pwrite = 1'b0;
	logic	[7:0]	paddr = 8'h00;
	logic	[31:0]	pwdata = 32'h0;
	logic	[31:0]	prdata, rd, v;
	logic			pready, pslverr, err, invert = 1'b0;
	logic			common_bus_clock, common_frame_pulse;
	logic	[63:0]	framer_byte = 64'h0, dbits, gbits;
	logic	[31:0]	framer_sig = 32'h0;
	logic	[7:0]	sig_multiframe_lost = 8'h00, base [8];
	logic	[39:0]	framer_slot_idx;
	logic	[7:0]	framer_rx_out_clock, framer_rx_data;
	logic	[1:0]	muxed_data_out, muxed_signaling_out, muxed_frame_pulse_out, q;
	int				fail_count = 0, checked = 0, fr, ofs, r0, r1;
	always #2.5 clk = ~clk;
	ersm_rx_sys_mux DUT (
		.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .common_bus_clock(common_bus_clock),
		.common_frame_pulse(common_frame_pulse), .framer_byte(framer_byte),
		.framer_sig(framer_sig), .sig_multiframe_lost(sig_multiframe_lost),
		.framer_slot_idx(framer_slot_idx), .framer_rx_out_clock(framer_rx_out_clock),
		.framer_rx_data(framer_rx_data), .muxed_data_out(muxed_data_out),
		.muxed_signaling_out(muxed_signaling_out),
		.muxed_frame_pulse_out(muxed_frame_pulse_out)
	);
	ersm_backplane BP (.invert(invert), .common_bus_clock(common_bus_clock),
		.common_frame_pulse(common_frame_pulse));
	function automatic logic [7:0] pat(input int n, input logic [4:0] s);
		return base[n] ^ {s, 3'b000};
	endfunction : pat
	function automatic logic [3:0] sg(input int n, input logic [4:0] s);
		return s[3:0] ^ 4'(n);
	endfunction : sg
	// Edge bits left equal (zero) in every framer that mk programs
	function automatic logic [31:0] mk(input logic s, input int o, input logic i, input logic f);
		return {9'h0, 7'(o), 2'b10, 1'b1, i, 7'h0, s, 1'b1, f, 2'b00};
	endfunction : mk
	// Framer cores answer the slot the design looks up
	always @(posedge clk) begin
		for (int n = 0; n < 8; n++) begin
			framer_byte[n*8 +: 8] <= pat(n, framer_slot_idx[n*5 +: 5]);
			framer_sig[n*4 +: 4] <= sg(n, framer_slot_idx[n*5 +: 5]);
		end
	end
	// One APB transfer, held until ready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		if (n >= 50) fail_count++;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic sample;
		@(posedge common_bus_clock);
		repeat (10) @(posedge clk);
	endtask : sample
	// Capture 64 bus bits from the marked frame start
	task automatic grab(input int b, input logic inv);
		int n;
		n = 0;
		do begin
			sample();
			n++;
		end while ((muxed_frame_pulse_out[b] ^ inv) !== 1'b1 && n < 1100);
		`CHK(n < 1100, 1'b1, "no frame mark")
		for (int i = 0; i < 64; i++) begin
			if (i > 0) sample();
			dbits = {dbits[62:0], muxed_data_out[b]};
			gbits = {gbits[62:0], muxed_signaling_out[b]};
		end
	endtask : grab
	task automatic check(input int f, input int o, input logic ones);
		for (int k = o; k < 8; k += 4) begin
			`CHK(dbits[63-8*k -: 8], pat(f, 5'((k-o)/4)), "bus byte")
			`CHK(gbits[63-8*k -: 8], {4'h0, ones ? 4'hf : sg(f, 5'((k-o)/4))}, "sig")
		end
	endtask : check
	task automatic close_out;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : close_out
	// Watchdog
	initial begin
		repeat (95000) @(posedge clk);
		fail_count++;
		close_out();
	end
	// Main sequence
	initial begin
		void'($urandom(84449));
		for (int n = 0; n < 8; n++) base[n] = 8'($urandom);
		fr = 1 + $urandom % 7;
		ofs = $urandom % 4;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		apb(0, 8'h00, 0);
		`CHK(rd, 32'h0, "cfg reset")
		apb(0, 8'h2c, 0);
		`CHK(rd, 32'h0, "idle reset")
		// Keep rate and edge choice clear: they are shared by all framers
		v = $urandom & 32'h007ff614;
		apb(1, 8'h1c, v);
		apb(0, 8'h1c, 0);
		`CHK(rd, v, "cfg readback")
		v = $urandom;
		apb(1, 8'h3c, v);
		apb(0, 8'h3c, 0);
		`CHK(rd, v, "idle readback")
		apb(0, 8'h48, 0);
		`CHK({err, rd}, {1'b1, 32'h0}, "unmapped read")
		apb(1, 8'h02, 0);
		`CHK(err, 1'b1, "unaligned write")
		$display("test registers done");
		apb(1, 8'h20, 32'hffffffff);
		apb(1, 8'h24, 32'h0);
		apb(1, 8'h40, 32'h2);
		repeat (600) @(posedge clk);
		r0 = 0;
		r1 = 0;
		repeat (2000) begin
			q = framer_rx_out_clock[1:0];
			@(posedge clk);
			r0 += int'(framer_rx_out_clock[0] === 1'b1 && q[0] === 1'b0);
			r1 += int'(framer_rx_out_clock[1] === 1'b1 && q[1] === 1'b0);
		end
		`CHK(r0 == 0, 1'b1, "gapped clock ran")
		`CHK(r1 >= 20 && r1 <= 21, 1'b1, "master rate")
		$display("test fractional done");
		apb(1, 8'h40, 32'h1);
		apb(1, 8'h00, mk(0, 0, 0, 0));
		apb(1, 8'(fr * 4), mk(1, ofs, 0, 0));
		sig_multiframe_lost <= 8'($urandom);
		grab(0, 0);
		check(0, 0, 0);
		grab(1, 0);
		check(fr, ofs, 0);
		$display("test buses done");
		sig_multiframe_lost <= 8'h01;
		apb(1, 8'h00, mk(0, 0, 0, 1));
		grab(0, 0);
		check(0, 0, 1);
		invert <= 1'b1;
		apb(1, 8'h00, mk(0, 0, 1, 1));
		grab(0, 1);
		check(0, 0, 1);
		$display("test signaling and invert done");
		close_out();
	end
endmodule : testbench
bind ersm_rx_sys_mux ersm_asserts #(.FRAMERS(FRAMERS)) u_chk (
	.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .common_bus_clock(common_bus_clock),
	.framer_rx_out_clock(framer_rx_out_clock), .muxed_data_out(muxed_data_out),
	.muxed_frame_pulse_out(muxed_frame_pulse_out)
);
